// File: src/motor_seq_params.svh
`ifndef MOTOR_SEQ_PARAMS_SVH
`define MOTOR_SEQ_PARAMS_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_HZ 100_000_000
`define TICK_MS 10
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`define MAX_TICKS 16'h1770

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_START_INJ 8'h04
`define OFS_BRAKE_TIME 8'h08
`define OFS_BRAKE_CFG 8'h0C
`define OFS_BOOST 8'h10
`define OFS_MOTOR 8'h14
`define OFS_RAMP 8'h18
`define OFS_TUNE 8'h1C
`define OFS_DWELL 8'h20
`define OFS_REGEN 8'h24
`define OFS_STATUS 8'h28
`define OFS_OUTPUT 8'h2C

// ---------------------------------------------------------------
// writable bit masks, reserved bits read zero
// ---------------------------------------------------------------
`define MASK_CTRL 32'h0000_00FF
`define MASK_START_INJ 32'h00FF_FFFF
`define MASK_BRAKE_CFG 32'h00FF_FFFF
`define MASK_BOOST 32'h0000_FFFF
`define MASK_MOTOR 32'hFFFF_01FF
`define MASK_REGEN 32'h03FF_03FF

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_CTRL 32'h0000_0000
`define RST_START_INJ 32'h0032_0000
`define RST_BRAKE_TIME 32'h0064_000A
`define RST_BRAKE_CFG 32'h0032_01F4
`define RST_BOOST 32'h0000_1414
`define RST_MOTOR 32'h1770_0000
`define RST_RAMP 32'h0001_0001
`define RST_TUNE 32'h0000_0000
`define RST_DWELL 32'h0000_0000
`define RST_REGEN 32'h0014_0280

// ---------------------------------------------------------------
// limits and scaling
// ---------------------------------------------------------------
`define MAX_LEVEL_PCT 8'hC8
`define MAX_BOOST 8'h96
`define MAX_ENTRY_FREQ 16'h1770
`define RATED_V_MIN 9'h0AA
`define RATED_V_MAX 9'h1E0
`define BOOST_DIV 32'h0000_03E8
`define RS_DIV 32'h0000_2710
`define LX_DIV 48'h0000_00F2_D922
`define V_OUT_MAX 10'h3FF

`endif

// File: src/motor_seq_pkg.sv
package motor_seq_pkg;

	// sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_START_INJ = 7'h02,
		ST_RUN = 7'h04,
		ST_DECEL = 7'h08,
		ST_DWELL = 7'h10,
		ST_BLANK = 7'h20,
		ST_BRAKE = 7'h40
	} seq_state_t;

	typedef enum logic [2:0] {
		STOP_RAMP = 3'h0,
		STOP_INJECT_STOP = 3'h1,
		STOP_COAST = 3'h2,
		STOP_REGEN = 3'h4
	} stop_mode_t;

	// control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic decel_stall_en;
		logic dwell_en;
		logic user_vf;
		logic boost_auto;
		logic [2:0] stop_method;
		logic inject_first_start;
	} ctrl_t;

	// drive command toward the power stage
	typedef struct packed {
		logic gate_en;
		logic dc_inject;
		logic [7:0] dc_level;
		logic reverse;
		logic [15:0] freq;
		logic [9:0] volt;
	} drive_t;

endpackage

// File: src/tick_counter.sv
`timescale 1ns/10ps

// loadable down counter, holds at zero
module tick_counter #(
	parameter int W = 16
) (
	input wire logic clk, // clock
	input wire logic rst_n, // sync reset, low
	input wire logic ce, // clock enable
	input wire logic load, // load strobe
	input wire logic [W-1:0] value, // load value
	input wire logic step, // count one down
	output logic zero // count is zero
);
	logic [W-1:0] cnt;

	// load wins over a step in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt <= '0;
		end else if (ce) begin
			if (load) begin
				cnt <= value;
			end else if (step && cnt != '0) begin
				cnt <= cnt - W'(1);
			end
		end
	end

	assign zero = (cnt == '0);
endmodule // tick_counter

// File: src/motor_seq.sv
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`include "motor_seq_params.svh"

module motor_seq
	import motor_seq_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic CORE_CLK, // 100 MHz clock
	input wire logic RST_N, // sync reset, low
	input wire logic CLK_EN, // freezes all state when low
	input wire logic HSEL, // ahb select
	input wire logic [31:0] HADDR, // ahb address
	input wire logic [1:0] HTRANS, // ahb transfer type
	input wire logic HWRITE, // ahb write
	input wire logic [2:0] HSIZE, // ahb size, word only
	input wire logic HREADY, // ahb bus ready
	input wire logic [31:0] HWDATA, // ahb write data
	output logic [31:0] HRDATA, // ahb read data
	output logic HREADYOUT, // ahb slave ready
	output logic HRESP, // ahb response, always okay
	input wire logic RUN_CMD, // run command level
	input wire logic REV_CMD, // reverse rotation request
	input wire logic [15:0] TARGET_FREQ, // target, 0.01 Hz
	input wire logic [9:0] DC_BUS_V, // dc bus volts
	input wire logic [9:0] INPUT_V, // mains volts
	input wire logic STALL_CURRENT, // current limit reached
	output drive_t DRIVE // power stage command
);
	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	logic [31:0] reg_ctrl, reg_start_inj, reg_brake_time, reg_brake_cfg;
	logic [31:0] reg_boost, reg_motor, reg_ramp, reg_tune, reg_dwell;
	logic [31:0] reg_regen;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic addr_phase;
	logic [31:0] rd_mux;
	seq_state_t state, next_state;
	logic [15:0] freq;
	logic [9:0] volt;
	logic reverse;
	logic [9:0] input_v_held;

	assign addr_phase = HSEL && HREADY && HTRANS[1];
	// stalling the bus is how a frozen block stays consistent
	assign HREADYOUT = CLK_EN;
	assign HRESP = 1'b0;

	// address phase capture
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (CLK_EN) begin
			wr_pend <= addr_phase && HWRITE;
			wr_addr <= HADDR[7:0];
		end
	end

	// data phase writes, masks keep reserved bits at zero
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			reg_ctrl <= `RST_CTRL;
			reg_start_inj <= `RST_START_INJ;
			reg_brake_time <= `RST_BRAKE_TIME;
			reg_brake_cfg <= `RST_BRAKE_CFG;
			reg_boost <= `RST_BOOST;
			reg_motor <= `RST_MOTOR;
			reg_ramp <= `RST_RAMP;
			reg_tune <= `RST_TUNE;
			reg_dwell <= `RST_DWELL;
			reg_regen <= `RST_REGEN;
		end else if (CLK_EN && wr_pend) begin
			case (wr_addr)
				`OFS_CTRL: reg_ctrl <= HWDATA & `MASK_CTRL;
				`OFS_START_INJ: reg_start_inj <= HWDATA & `MASK_START_INJ;
				`OFS_BRAKE_TIME: reg_brake_time <= HWDATA;
				`OFS_BRAKE_CFG: reg_brake_cfg <= HWDATA & `MASK_BRAKE_CFG;
				`OFS_BOOST: reg_boost <= HWDATA & `MASK_BOOST;
				`OFS_MOTOR: reg_motor <= HWDATA & `MASK_MOTOR;
				`OFS_RAMP: reg_ramp <= HWDATA;
				`OFS_TUNE: reg_tune <= HWDATA;
				`OFS_DWELL: reg_dwell <= HWDATA;
				`OFS_REGEN: reg_regen <= HWDATA & `MASK_REGEN;
				default: ;
			endcase
		end
	end

	// read mux, unmapped offsets read zero
	always_comb begin
		case (HADDR[7:0])
			`OFS_CTRL: rd_mux = reg_ctrl;
			`OFS_START_INJ: rd_mux = reg_start_inj;
			`OFS_BRAKE_TIME: rd_mux = reg_brake_time;
			`OFS_BRAKE_CFG: rd_mux = reg_brake_cfg;
			`OFS_BOOST: rd_mux = reg_boost;
			`OFS_MOTOR: rd_mux = reg_motor;
			`OFS_RAMP: rd_mux = reg_ramp;
			`OFS_TUNE: rd_mux = reg_tune;
			`OFS_DWELL: rd_mux = reg_dwell;
			`OFS_REGEN: rd_mux = reg_regen;
			`OFS_STATUS: rd_mux = {13'h0000, reverse, input_v_held, 1'b0,
				state};
			`OFS_OUTPUT: rd_mux = {6'h00, volt, freq};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data registered in the address phase, so a read that
	// directly follows a write to the same word returns the old value
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			HRDATA <= 32'h0000_0000;
		end else if (CLK_EN && addr_phase && !HWRITE) begin
			HRDATA <= rd_mux;
		end
	end

	// ---------------------------------------------------------------
	// settings with clamping
	// ---------------------------------------------------------------
	ctrl_t ctrl;
	logic [15:0] start_ticks, blank_ticks, brake_ticks, dwell_ticks;
	logic [7:0] start_level, brake_level;
	logic [15:0] entry_freq, dwell_freq, base_freq, acc_step, dec_step;
	logic [8:0] rated_v;
	logic [9:0] regen_thr, regen_hyst;

	function automatic logic [15:0] clamp_ticks(input logic [15:0] t);
		clamp_ticks = (t > `MAX_TICKS) ? `MAX_TICKS : t;
	endfunction

	function automatic logic [7:0] clamp_pct(input logic [7:0] p);
		clamp_pct = (p > `MAX_LEVEL_PCT) ? `MAX_LEVEL_PCT : p;
	endfunction

	// a rated value between 1 and 169 is forced up to the minimum
	always_comb begin
		ctrl = ctrl_t'(reg_ctrl[7:0]);
		start_ticks = clamp_ticks(reg_start_inj[15:0]);
		start_level = clamp_pct(reg_start_inj[23:16]);
		blank_ticks = clamp_ticks(reg_brake_time[15:0]);
		brake_ticks = clamp_ticks(reg_brake_time[31:16]);
		brake_level = clamp_pct(reg_brake_cfg[23:16]);
		entry_freq = (reg_brake_cfg[15:0] > `MAX_ENTRY_FREQ) ?
			`MAX_ENTRY_FREQ : reg_brake_cfg[15:0];
		dwell_freq = reg_dwell[15:0];
		dwell_ticks = clamp_ticks(reg_dwell[31:16]);
		base_freq = (reg_motor[31:16] == 16'h0000) ? 16'h0001 :
			reg_motor[31:16];
		rated_v = reg_motor[8:0];
		if (rated_v != 9'h000 && rated_v < `RATED_V_MIN) begin
			rated_v = `RATED_V_MIN;
		end else if (rated_v > `RATED_V_MAX) begin
			rated_v = `RATED_V_MAX;
		end
		acc_step = reg_ramp[15:0];
		dec_step = reg_ramp[31:16];
		regen_thr = reg_regen[9:0];
		regen_hyst = reg_regen[25:16];
	end

	// ---------------------------------------------------------------
	// 10 ms tick and interval timer
	// ---------------------------------------------------------------
	logic presc_zero, tick, tmr_load, tmr_zero;
	logic [15:0] tmr_value;

	// prescaler reloads itself each time it expires, and restarts
	// with every interval so no interval loses a partial first tick
	tick_counter #(.W(24)) u_presc (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.ce(CLK_EN),
		.load(presc_zero || tmr_load),
		.value(24'(TICK_CYCLES - 1)),
		.step(1'b1),
		.zero(presc_zero)
	);
	assign tick = presc_zero;

	tick_counter #(.W(16)) u_interval (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.ce(CLK_EN),
		.load(tmr_load),
		.value(tmr_value),
		.step(tick),
		.zero(tmr_zero)
	);

	// timer reloads on every state change with the new interval
	always_comb begin
		tmr_load = (next_state != state);
		case (next_state)
			ST_START_INJ: tmr_value = start_ticks;
			ST_BLANK: tmr_value = blank_ticks;
			ST_BRAKE: tmr_value = brake_ticks;
			ST_DWELL: tmr_value = dwell_ticks;
			default: tmr_value = 16'h0000;
		endcase
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	logic dwell_done, dwell_hit, brake_mode, skip_dwell;

	assign brake_mode = (ctrl.stop_method == STOP_INJECT_STOP);
	assign skip_dwell = brake_mode && (dwell_freq < entry_freq);
	assign dwell_hit = ctrl.dwell_en && !dwell_done && !skip_dwell &&
		(freq <= dwell_freq) && (dwell_freq != 16'h0000);

	// run level is sampled each cycle; a returning run during
	// deceleration resumes without a new start sequence
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (RUN_CMD) begin
					next_state = ctrl.inject_first_start ? ST_START_INJ :
						ST_RUN;
				end
			end
			ST_START_INJ: begin
				if (!RUN_CMD) begin
					next_state = ST_IDLE;
				end else if (tmr_zero) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!RUN_CMD) begin
					next_state = (ctrl.stop_method == STOP_COAST) ?
						ST_IDLE : ST_DECEL;
				end
			end
			ST_DECEL: begin
				if (RUN_CMD) begin
					next_state = ST_RUN;
				end else if (brake_mode && freq <= entry_freq) begin
					next_state = ST_BLANK;
				end else if (dwell_hit) begin
					next_state = ST_DWELL;
				end else if (freq == 16'h0000) begin
					next_state = ST_IDLE;
				end
			end
			ST_DWELL: begin
				if (RUN_CMD) begin
					next_state = ST_RUN;
				end else if (tmr_zero) begin
					next_state = ST_DECEL;
				end
			end
			ST_BLANK: begin
				if (tmr_zero) begin
					next_state = ST_BRAKE;
				end
			end
			ST_BRAKE: begin
				if (tmr_zero) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			state <= ST_IDLE;
		end else if (CLK_EN) begin
			state <= next_state;
		end
	end

	// dwell happens once per stop
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			dwell_done <= 1'b0;
		end else if (CLK_EN) begin
			if (state == ST_DWELL) begin
				dwell_done <= 1'b1;
			end else if (state == ST_RUN || state == ST_IDLE) begin
				dwell_done <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// frequency ramp, one step per tick
	// ---------------------------------------------------------------
	logic over_bus, far_over_bus;
	logic [16:0] up_sum, regen_sum;

	assign over_bus = DC_BUS_V > regen_thr;
	assign far_over_bus = {1'b0, DC_BUS_V} > ({1'b0, regen_thr} +
		{1'b0, regen_hyst});
	assign up_sum = {1'b0, freq} + {1'b0, acc_step};
	assign regen_sum = {1'b0, freq} + {2'b00, dec_step[15:1]};

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			freq <= 16'h0000;
		end else if (CLK_EN) begin
			if (next_state == ST_IDLE || next_state == ST_START_INJ ||
				next_state == ST_BLANK) begin
				freq <= 16'h0000;
			end else if (tick && state == ST_RUN) begin
				if (freq < TARGET_FREQ) begin
					freq <= (up_sum[15:0] > TARGET_FREQ || up_sum[16]) ?
						TARGET_FREQ : up_sum[15:0];
				end else if (freq > TARGET_FREQ) begin
					freq <= (freq - TARGET_FREQ < dec_step) ? TARGET_FREQ :
						freq - dec_step;
				end
			end else if (tick && state == ST_DECEL) begin
				if (ctrl.stop_method == STOP_REGEN && over_bus) begin
					// regen takes precedence over the stall hold
					if (far_over_bus) begin
						freq <= (regen_sum[16] || regen_sum[15:0] > TARGET_FREQ) ?
							TARGET_FREQ : regen_sum[15:0];
					end else begin
						freq <= (freq < (dec_step >> 1)) ? 16'h0000 :
							freq - (dec_step >> 1);
					end
				end else if (ctrl.decel_stall_en && STALL_CURRENT &&
					ctrl.stop_method != STOP_REGEN) begin
					freq <= freq;
				end else begin
					freq <= (freq < dec_step) ? 16'h0000 :
						freq - dec_step;
				end
			end
		end
	end

	// direction follows the request only while stopped
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			reverse <= 1'b0;
		end else if (CLK_EN && state == ST_IDLE) begin
			reverse <= REV_CMD;
		end
	end

	// ---------------------------------------------------------------
	// output voltage and boost
	// ---------------------------------------------------------------
	logic [9:0] v_ref, v_above, next_volt;
	logic [31:0] v_lin, boost_v, taper_v, auto_v, v_sum;
	logic [47:0] lx_prod;
	logic [7:0] boost_pct;

	// mains level is caught only while the motor stands still
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			input_v_held <= 10'h000;
		end else if (CLK_EN && state == ST_IDLE) begin
			input_v_held <= INPUT_V;
		end
	end

	// division is slow but must settle within one clock, as volt samples it every cycle
	always_comb begin
		v_ref = (rated_v == 9'h000) ? input_v_held : {1'b0, rated_v};
		v_above = (rated_v == 9'h000 || INPUT_V < {1'b0, rated_v}) ?
			INPUT_V : {1'b0, rated_v};
		v_lin = (32'(v_ref) * 32'(freq)) / 32'(base_freq);
		boost_pct = reverse ? reg_boost[15:8] : reg_boost[7:0];
		if (boost_pct > `MAX_BOOST) begin
			boost_pct = `MAX_BOOST;
		end
		lx_prod = 48'(reg_tune[23:12]) * 48'(reg_tune[31:24]) *
			48'(base_freq);
		auto_v = (32'(reg_tune[11:0]) * 32'(reg_tune[31:24])) / `RS_DIV +
			32'(lx_prod / `LX_DIV);
		if (ctrl.boost_auto) begin
			boost_v = auto_v;
		end else if (ctrl.user_vf) begin
			boost_v = 32'h0000_0000;
		end else begin
			boost_v = (32'(v_ref) * 32'(boost_pct)) / `BOOST_DIV;
		end
		taper_v = (boost_v * 32'(base_freq - freq)) / 32'(base_freq);
		v_sum = v_lin + taper_v;
		if (freq >= base_freq) begin
			next_volt = v_above;
		end else if (v_sum > 32'(`V_OUT_MAX)) begin
			next_volt = `V_OUT_MAX;
		end else begin
			next_volt = v_sum[9:0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			volt <= 10'h000;
		end else if (CLK_EN) begin
			volt <= (freq == 16'h0000) ? 10'h000 : next_volt;
		end
	end

	// ---------------------------------------------------------------
	// drive outputs, registered
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			DRIVE <= '0;
		end else if (CLK_EN) begin
			DRIVE.gate_en <= (state != ST_IDLE) && (state != ST_BLANK);
			DRIVE.dc_inject <= (state == ST_START_INJ) ||
				(state == ST_BRAKE);
			case (state)
				ST_START_INJ: DRIVE.dc_level <= start_level;
				ST_BRAKE: DRIVE.dc_level <= brake_level;
				default: DRIVE.dc_level <= 8'h00;
			endcase
			DRIVE.reverse <= reverse;
			DRIVE.freq <= freq;
			DRIVE.volt <= volt;
		end
	end
endmodule // motor_seq

// File: verification/motor_seq_checker.sv
`timescale 1ns/10ps

module motor_seq_checker
	import motor_seq_pkg::*;
#(
	parameter int TICK_CYCLES = 10
) (
	input wire logic CORE_CLK, // clock
	input wire logic RST_N, // sync reset, low
	input wire logic CLK_EN, // clock enable
	input wire logic RUN_CMD, // run level
	input wire logic HREADYOUT, // slave ready
	input wire logic HRESP, // slave response
	input wire drive_t DRIVE // power stage command
);
	// -----------------------------
	// bus and drive properties
	// -----------------------------
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	// zero wait slave, stalls only while frozen
	a_ready_follows_en: assert property (HREADYOUT == CLK_EN)
		else $error("ready differs from clock enable");
	a_resp_always_okay: assert property (HRESP == 1'b0)
		else $error("slave response not okay");
	a_inject_level_cap: assert property (
		DRIVE.dc_inject |-> DRIVE.dc_level <= 8'hC8)
		else $error("injection level above limit");
	// dc injection carries no rotating field
	a_inject_no_freq: assert property (
		DRIVE.dc_inject |-> DRIVE.freq == 16'h0000 && DRIVE.gate_en)
		else $error("injection with frequency or blocked output");
	// frequency only moves on ticks, so it rests between them
	a_freq_on_ticks: assert property (
		TICK_CYCLES > 8 && CLK_EN && $changed(DRIVE.freq) &&
		DRIVE.freq != 16'h0000 |=>
		(DRIVE.freq == 16'h0000 || $stable(DRIVE.freq))[*8])
		else $error("frequency moved between ticks");
	a_volt_zero_stop: assert property (
		$past(DRIVE.freq) == 16'h0000 && DRIVE.freq == 16'h0000 |->
		DRIVE.volt == 10'h000)
		else $error("voltage without frequency");
	// direct start follows a run request two cycles earlier
	a_start_needs_run: assert property (
		$rose(DRIVE.gate_en) && !DRIVE.dc_inject |-> $past(RUN_CMD, 2))
		else $error("output enabled without run");
	a_level_steady: assert property (
		DRIVE.dc_inject && $past(DRIVE.dc_inject) |-> $stable(DRIVE.dc_level))
		else $error("injection level changed mid interval");
	a_dir_steady: assert property (
		DRIVE.gate_en && $past(DRIVE.gate_en) |-> $stable(DRIVE.reverse))
		else $error("direction changed while driving");
endmodule // motor_seq_checker

bind motor_seq motor_seq_checker #(.TICK_CYCLES(TICK_CYCLES)) checker_inst (
	.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .RUN_CMD(RUN_CMD),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .DRIVE(DRIVE)
);

// File: verification/motor_model.sv
`timescale 1ns/10ps

// motor and bus capacitor seen from the power stage
module motor_model
	import motor_seq_pkg::*;
(
	input wire drive_t drive, // power stage command
	input wire logic [1:0] bus_level, // regen strength chosen by bench
	input wire logic stall_req, // load step chosen by bench
	output logic [9:0] dc_bus_v, // bus volts
	output logic stall_current // current limit hit
);
	// regen only pumps the bus while a field is driven
	always_comb begin
		dc_bus_v = 10'h230;
		if (drive.gate_en && drive.freq != 16'h0000) begin
			if (bus_level == 2'h2)
				dc_bus_v = 10'h2BC;
			else if (bus_level == 2'h1)
				dc_bus_v = 10'h28A;
		end
		stall_current = stall_req && drive.gate_en;
	end
endmodule // motor_model

// File: verification/motor_seq_tb.sv
`timescale 1ns/10ps
`include "motor_seq_params.svh"

module motor_seq_tb
	import motor_seq_pkg::*;
;
	localparam int TC = 10;
	logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, hsel = 1'b0;
	logic hwrite = 1'b0, run = 1'b0, rev = 1'b0, stall_req = 1'b0;
	logic [1:0] htrans = 2'h0, bus_level = 2'h0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
	logic [15:0] target = 16'h0000;
	logic [9:0] input_v = 10'h0F0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, stall;
	logic [9:0] dc_bus_v;
	drive_t drive;
	int mismatches = 0, comparisons = 0, n, tgt, e;
	logic [7:0] ofs [8] = '{`OFS_CTRL, `OFS_START_INJ, `OFS_BRAKE_TIME,
		`OFS_BRAKE_CFG, `OFS_BOOST, `OFS_MOTOR, `OFS_RAMP, `OFS_REGEN};
	logic [31:0] rv [8] = '{`RST_CTRL, `RST_START_INJ, `RST_BRAKE_TIME,
		`RST_BRAKE_CFG, `RST_BOOST, `RST_MOTOR, `RST_RAMP, `RST_REGEN};
	// ctrl, reverse, target, mains volts, rated volts
	int tab [8][5] = '{'{0, 0, 500, 240, 200}, '{32, 0, 500, 240, 200},
		'{0, 1, 500, 240, 200}, '{16, 0, 500, 240, 200},
		'{0, 0, 1000, 300, 200}, '{0, 0, 1000, 150, 200},
		'{0, 0, 500, 240, 0}, '{0, 0, 1000, 250, 0}};

	// free running core clock
	always #5 clk = ~clk;

	motor_seq #(.TICK_CYCLES(TC)) motor_seq_inst (
		.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .RUN_CMD(run), .REV_CMD(rev),
		.TARGET_FREQ(target), .DC_BUS_V(dc_bus_v), .INPUT_V(input_v),
		.STALL_CURRENT(stall), .DRIVE(drive)
	);

	motor_model motor_model_inst (.drive(drive), .bus_level(bus_level),
		.stall_req(stall_req), .dc_bus_v(dc_bus_v), .stall_current(stall));

	// -----------------------------
	// helpers
	// -----------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task rng(input int v, input int lo, input int hi);
		chk({31'h0, v >= lo && v <= hi}, 32'h0000_0001);
	endtask

	task results;
		if (mismatches == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one single word transfer, address phase held until ready
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, x);
	endtask

	function automatic bit at(int w, int v);
		case (w)
			0: return drive.freq === 16'(v);
			1: return drive.gate_en === v[0];
			default: return drive.dc_inject === v[0];
		endcase
	endfunction

	// counts cycles while the watched field stays as given
	task cnt(input int w, input int v, input bit eq, output int k);
		k = 0;
		while (k < 20000 && at(w, v) == eq) begin
			@(posedge clk);
			k++;
		end
	endtask

	task go(input int t);
		@(posedge clk);
		run <= 1'b1;
		target <= 16'(t);
		cnt(0, t, 1'b0, n);
	endtask

	task halt;
		@(posedge clk);
		run <= 1'b0;
		cnt(1, 1, 1'b1, n);
	endtask

	// expected voltage, boost fades linearly up to base of 10 Hz
	function automatic int ev(int c, int r, int f, int iv, int rt);
		int vr;
		int bv;
		vr = (rt != 0) ? rt : iv;
		if (f >= 1000)
			return (rt != 0 && rt < iv) ? rt : iv;
		bv = c[4] ? 1000 * 40 / 10000 : c[5] ? 0 : vr * (r ? 50 : 100) / 1000;
		return vr * f / 1000 + bv * (1000 - f) / 1000;
	endfunction

	// watchdog, generous against the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		results();
	end

	// -----------------------------
	// main sequence
	// -----------------------------
	initial begin
		void'($urandom(32'h791a_7a97));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			rdc(ofs[i], rv[i]);
		rdc(`OFS_STATUS, 32'h0000_F001);
		wr(8'h40, 32'hFFFF_FFFF);
		rdc(8'h40, 32'h0000_0000);
		wr(`OFS_STATUS, 32'hFFFF_FFFF);
		rdc(`OFS_STATUS, 32'h0000_F001);
		wr(`OFS_CTRL, 32'hFFFF_FFFF);
		rdc(`OFS_CTRL, 32'h0000_00FF);
		@(posedge clk);
		clk_en <= 1'b0;
		@(posedge clk);
		chk({31'h0, hreadyout}, 32'h0000_0000);
		chk({31'h0, hresp}, 32'h0000_0000);
		clk_en <= 1'b1;
		// direct start to a random target, then ramp stop
		wr(`OFS_RAMP, 32'h0064_0064);
		wr(`OFS_CTRL, 32'h0000_0000);
		tgt = 100 * (2 + $urandom % 8);
		@(posedge clk);
		run <= 1'b1;
		target <= 16'(tgt);
		cnt(0, 0, 1'b1, n);
		rng(n, 1, TC + 3);
		cnt(0, tgt, 1'b0, n);
		halt;
		chk(drive.freq, 32'h0000_0000);
		rdc(`OFS_STATUS, 32'h0000_F001);
		// injection first start, then coast stop
		wr(`OFS_START_INJ, 32'h0078_0005);
		wr(`OFS_CTRL, 32'h0000_0001);
		@(posedge clk);
		run <= 1'b1;
		target <= 16'h03E8;
		cnt(2, 1, 1'b0, n);
		chk(drive.dc_level, 32'h0000_0078);
		cnt(2, 1, 1'b1, n);
		rng(n, 5 * TC - 1, 6 * TC + 2);
		cnt(0, 1000, 1'b0, n);
		wr(`OFS_CTRL, 32'h0000_0005);
		@(posedge clk);
		run <= 1'b0;
		cnt(1, 1, 1'b1, n);
		rng(n, 1, 4);
		chk(drive.freq, 32'h0000_0000);
		// brake stop with a dwell below the entry point
		wr(`OFS_BRAKE_TIME, 32'h0004_0003);
		wr(`OFS_BRAKE_CFG, 32'h004D_01F4);
		wr(`OFS_DWELL, 32'h0010_012C);
		wr(`OFS_CTRL, 32'h0000_0042);
		go(1000);
		@(posedge clk);
		run <= 1'b0;
		cnt(1, 1, 1'b1, n);
		rng(n, 4 * TC, 5 * TC + 4);
		cnt(1, 0, 1'b1, n);
		rng(n, 3 * TC - 1, 4 * TC + 2);
		chk(drive.dc_level, 32'h0000_004D);
		cnt(2, 1, 1'b1, n);
		rng(n, 4 * TC - 1, 5 * TC + 2);
		chk(drive.gate_en, 32'h0000_0000);
		// regen stop: overvoltage holds the target, mild bus halves the slope
		wr(`OFS_CTRL, 32'h0000_0088);
		go(1000);
		@(posedge clk);
		bus_level <= 2'h2;
		run <= 1'b0;
		repeat (5 * TC) @(posedge clk);
		chk(drive.freq, 32'h0000_03E8);
		bus_level <= 2'h1;
		stall_req <= 1'b1;
		repeat (4 * TC) @(posedge clk);
		rng(drive.freq, 750, 950);
		bus_level <= 2'h0;
		stall_req <= 1'b0;
		cnt(1, 1, 1'b1, n);
		// stall hold in ramp stop keeps the frequency
		wr(`OFS_CTRL, 32'h0000_0080);
		go(1000);
		@(posedge clk);
		stall_req <= 1'b1;
		run <= 1'b0;
		repeat (4 * TC) @(posedge clk);
		chk(drive.freq, 32'h0000_03E8);
		stall_req <= 1'b0;
		cnt(1, 1, 1'b1, n);
		// ramp stop with a dwell above zero, held once for its time
		wr(`OFS_CTRL, 32'h0000_0040);
		go(1000);
		halt;
		rng(n, 26 * TC, 27 * TC);
		// voltage table: boost kinds, direction, rated and mains
		wr(`OFS_BOOST, 32'h0000_3264);
		wr(`OFS_TUNE, 32'h2800_03E8);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			rev <= tab[i][1][0];
			input_v <= 10'(tab[i][3]);
			wr(`OFS_MOTOR, {16'h03E8, 7'h00, 9'(tab[i][4])});
			wr(`OFS_CTRL, 32'(tab[i][0]));
			go(tab[i][2]);
			repeat (3) @(posedge clk);
			e = ev(tab[i][0], tab[i][1], tab[i][2], tab[i][3], tab[i][4]);
			chk(drive.reverse, 32'(tab[i][1]));
			chk(drive.volt, 32'(e[9:0]));
			rdc(`OFS_OUTPUT, {6'h00, e[9:0], tab[i][2][15:0]});
			halt;
		end
		results();
	end
endmodule // motor_seq_tb
